// ==== hdl/eedip_top.sv ====
// I2C slave with EEPROM DIP switch multiplexer, GPIO expander and storage
//
// Contract
// - Output force low at 0 drives every multiplexed output low.
// - GPIO force low at 0 drives all eight GPIO pins low.
// - Source select picks for all five multiplexed bits together between hardware inputs and stored switch value.
// - Transfers start with six fixed bits, one strap bit and a direction bit; only a match answers.
// - The address strap pin supplies the programmable address bit.
// - Eight data bits follow the address acknowledge in the addressed direction.
// - Received data goes to memory or switch storage only when direction is 0 and write protect is 0.
// - With direction 1 the device returns data to the master.
// - Write protect high blocks every EEPROM programming operation.
// - After reset all GPIO pins are configured as open-drain outputs.
// - Active-low reset returns the eight GPIO pins to their default state.
// - A 2048-bit memory is written and read from I2C and via GPIO transfers.
// - The selected switch setting is kept in storage that reset does not clear.
// - Select 0 drives outputs from stored value, select 1 drives the multiplexed outputs from hardware inputs.
// - The single latched output captures on select rising edge, transparent while low.
`include "eedip_cfg.svh"
`default_nettype none
module eedip_top (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_strap,
  input wire logic write_protect,
  input wire logic source_select,
  input wire logic output_force_lown,
  input wire logic gpio_force_lown,
  input wire logic [`EEDIP_MUX_W-1:0] mux_in,
  output eedip_pkg::eedip_sw_out_t sw_drive_low,
  input wire logic [`EEDIP_GPIO_W-1:0] gpio_in,
  output logic [`EEDIP_GPIO_W-1:0] gpio_out,
  output logic [`EEDIP_GPIO_W-1:0] gpio_oe
);
  eedip_pkg::eedip_state_t state;
  logic scl_q, sda_q;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic rw;
  logic have_cmd;
  logic [7:0] cmd;
  logic [`EEDIP_MEM_AW-1:0] mem_ptr;
  logic [7:0] mem [`EEDIP_MEM_DEPTH];
  logic [`EEDIP_SW_W-1:0] sw_store;
  logic [7:0] out_reg;
  logic [7:0] cfg_reg;
  logic sel_q;
  logic latch_val;
  logic [7:0] rd_byte;
  logic wr_ok;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  eedip_pkg::eedip_sw_out_t sw_val;
  logic addr_rise_seen;
  logic byte_acked;

  // Bus conditions from the sampled line levels
  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign start_cond = scl && scl_q && sda_q && !sda_in;
  assign stop_cond = scl && scl_q && !sda_q && sda_in;
  assign wr_ok = !rw && !write_protect;
  assign byte_acked = (state == eedip_pkg::ST_WACK) && scl_fall;

  // Byte returned to a reading master
  always_comb begin
    case (cmd)
      `EEDIP_CMD_MEM_RD: rd_byte = mem[mem_ptr];
      `EEDIP_CMD_SW_RD: rd_byte = {2'h0, sw_store};
      `EEDIP_CMD_IN_RD: rd_byte = gpio_in;
      `EEDIP_CMD_OUT: rd_byte = out_reg;
      `EEDIP_CMD_CFG: rd_byte = cfg_reg;
      `EEDIP_CMD_MUXIN: rd_byte = {3'h0, mux_in};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // Serial protocol engine
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= eedip_pkg::ST_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      have_cmd <= 1'b0;
      addr_rise_seen <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      state <= eedip_pkg::ST_ADDR;
      bit_cnt <= 3'h0;
      have_cmd <= 1'b0;
      addr_rise_seen <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state <= eedip_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        eedip_pkg::ST_ADDR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_in};
            bit_cnt <= bit_cnt + 3'h1;
            addr_rise_seen <= 1'b1;
          end
          // Clock fall closing START also finds the count at zero
          if (scl_fall && bit_cnt == 3'h0 && addr_rise_seen) begin
            if (shreg[7:1] == {`EEDIP_ADDR_FIXED, address_strap}) begin
              rw <= shreg[0];
              sda_oe <= 1'b1;
              state <= eedip_pkg::ST_ADDR_ACK;
            end else begin
              state <= eedip_pkg::ST_SKIP;
            end
          end
        end
        eedip_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            if (rw) begin
              shreg <= rd_byte;
              sda_oe <= !rd_byte[7];
              state <= eedip_pkg::ST_RDATA;
            end else begin
              sda_oe <= 1'b0;
              state <= eedip_pkg::ST_WDATA;
            end
          end
        end
        eedip_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_in};
            bit_cnt <= bit_cnt + 3'h1;
          end
          // Refused memory and switch write bytes are not acknowledged
          if (scl_fall && bit_cnt == 3'h0) begin
            sda_oe <= !(have_cmd && write_protect &&
              (cmd == `EEDIP_CMD_MEM_WR || cmd == `EEDIP_CMD_SW_WR));
            state <= eedip_pkg::ST_WACK;
          end
        end
        eedip_pkg::ST_WACK: begin
          if (scl_fall) begin
            have_cmd <= 1'b1;
            sda_oe <= 1'b0;
            state <= eedip_pkg::ST_WDATA;
          end
        end
        eedip_pkg::ST_RDATA: begin
          if (scl_fall) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == `EEDIP_BIT_LAST) begin
              sda_oe <= 1'b0;
              state <= eedip_pkg::ST_RACK;
            end else begin
              sda_oe <= !shreg[6];
              shreg <= {shreg[6:0], 1'b0};
            end
          end
        end
        eedip_pkg::ST_RACK: begin
          if (scl_rise && sda_in) begin
            state <= eedip_pkg::ST_SKIP;
          end else if (scl_fall) begin
            shreg <= rd_byte;
            sda_oe <= !rd_byte[7];
            bit_cnt <= 3'h0;
            state <= eedip_pkg::ST_RDATA;
          end
        end
        eedip_pkg::ST_SKIP: sda_oe <= 1'b0;
        default: state <= eedip_pkg::ST_IDLE;
      endcase
    end
  end

  // Command byte and memory pointer
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cmd <= 8'h00;
      mem_ptr <= '0;
    end else if (byte_acked) begin
      // First byte after the address is the command
      if (!have_cmd) begin
        cmd <= shreg;
      end else if (cmd == `EEDIP_CMD_MEM_WR || cmd == `EEDIP_CMD_MEM_RD) begin
        mem_ptr <= mem_ptr + 1'b1;
      end
    end else if (state == eedip_pkg::ST_RACK && scl_fall && cmd == `EEDIP_CMD_MEM_RD) begin
      mem_ptr <= mem_ptr + 1'b1;
    end
  end

  // Storage: no reset, contents survive like non-volatile cells
  always_ff @(posedge sys_clk) begin
    if (byte_acked && have_cmd && wr_ok) begin
      if (cmd == `EEDIP_CMD_MEM_WR) begin
        mem[mem_ptr] <= shreg;
      end else if (cmd == `EEDIP_CMD_IN_TO_MEM) begin
        mem[mem_ptr] <= gpio_in;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (byte_acked && have_cmd && wr_ok && cmd == `EEDIP_CMD_SW_WR) begin
      sw_store <= shreg[`EEDIP_SW_W-1:0];
    end
  end

  // GPIO registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      out_reg <= `EEDIP_OUT_RESET;
      cfg_reg <= `EEDIP_CFG_RESET;
    end else if (byte_acked && have_cmd && !rw) begin
      case (cmd)
        `EEDIP_CMD_OUT: out_reg <= shreg;
        `EEDIP_CMD_CFG: cfg_reg <= shreg;
        `EEDIP_CMD_MEM_TO_OUT: out_reg <= mem[mem_ptr];
        default: out_reg <= out_reg;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `EEDIP_GPIO_W; gi++) begin : g_gpio
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          gpio_oe[gi] <= 1'b0;
        end else begin
          gpio_oe[gi] <= !gpio_force_lown || (cfg_reg[gi] && !out_reg[gi]);
        end
      end
    end
  endgenerate

  // Open drain: pins only ever pull low
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gpio_out <= 8'h00;
    end else begin
      gpio_out <= 8'h00;
    end
  end

  // Switch multiplexer and latched single output
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      // Idle high, so leaving reset makes no false select edge
      sel_q <= 1'b1;
      latch_val <= 1'b0;
    end else begin
      sel_q <= source_select;
      if (!source_select) begin
        latch_val <= sw_store[`EEDIP_SW_W-1];
      end else if (!sel_q) begin
        latch_val <= sw_store[`EEDIP_SW_W-1];
      end
    end
  end

  always_comb begin
    sw_val.mux_out = source_select ? mux_in : sw_store[`EEDIP_MUX_W-1:0];
    sw_val.latched_single_output = source_select ? latch_val : sw_store[`EEDIP_SW_W-1];
    if (!output_force_lown) begin
      sw_val = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sw_drive_low <= '1;
    end else begin
      sw_drive_low <= ~sw_val;
    end
  end
endmodule
`default_nettype wire

// ==== inc/eedip_cfg.svh ====
// Constants for the EEPROM DIP switch and I/O expander block
`ifndef EEDIP_CFG_SVH
`define EEDIP_CFG_SVH
`define EEDIP_ADDR_FIXED 6'h2_A
`define EEDIP_MUX_W 5
`define EEDIP_GPIO_W 8
`define EEDIP_MEM_DEPTH 256
`define EEDIP_MEM_AW 8
`define EEDIP_SW_W 6
`define EEDIP_BIT_LAST 3'h7
`define EEDIP_CMD_MEM_WR 8'h01
`define EEDIP_CMD_MEM_RD 8'h03
`define EEDIP_CMD_SW_WR 8'h04
`define EEDIP_CMD_SW_RD 8'h06
`define EEDIP_CMD_IN_RD 8'h07
`define EEDIP_CMD_OUT 8'h08
`define EEDIP_CMD_CFG 8'h0A
`define EEDIP_CMD_MUXIN 8'h0C
`define EEDIP_CMD_MEM_TO_OUT 8'h0F
`define EEDIP_CMD_IN_TO_MEM 8'h12
`define EEDIP_CFG_RESET 8'hFF
`define EEDIP_OUT_RESET 8'h00
`define EEDIP_SW_RESET 6'h00
`endif

// ==== inc/eedip_pkg.sv ====
// Types for the EEPROM DIP switch and I/O expander block
`default_nettype none
package eedip_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK, ST_SKIP
  } eedip_state_t;
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] drive_low;
  } eedip_gpio_t;
  typedef struct packed {
    logic [4:0] mux_out;
    logic latched_single_output;
  } eedip_sw_out_t;
endpackage
`default_nettype wire

// ==== test/eedip_top_sva.sv ====
// Port checker for the EEPROM DIP switch block
`default_nettype none
module eedip_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic source_select,
  input wire logic output_force_lown,
  input wire logic gpio_force_lown,
  input wire logic [4:0] mux_in,
  input wire eedip_pkg::eedip_sw_out_t sw_drive_low,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_OUT_LOW: assert property (!output_force_lown |=> sw_drive_low.mux_out == 5'h1F)
    else $error("mux not forced");
  AST_GPIO_LOW: assert property (!gpio_force_lown |=> gpio_oe == 8'hFF)
    else $error("gpio not forced");
  AST_MUX_HW: assert property (resetn && output_force_lown && source_select |=>
    sw_drive_low.mux_out == ~$past(mux_in))
    else $error("mux not from inputs");
  AST_OPEN_DRAIN: assert property (sda_out == 1'h0 && gpio_out == 8'h00)
    else $error("pin driven high");
  AST_RST_IDLE: assert property ($rose(resetn) |-> gpio_oe == 8'h00 && !sda_oe)
    else $error("pins not idle");
  AST_ACK_LOW: assert property ($rose(sda_oe) |-> !scl)
    else $error("data moved in clock high");
  AST_ACK_HOLD: assert property (sda_oe && scl && $past(scl) |=> sda_oe)
    else $error("data dropped in clock high");
  AST_LATCH_HOLD: assert property ($past(resetn) && output_force_lown &&
    $past(output_force_lown) && source_select && $past(source_select)
    |=> $stable(sw_drive_low.latched_single_output))
    else $error("latch moved");
endmodule
bind eedip_top eedip_chk chk_u (.*);
`default_nettype wire

// ==== test/eedip_master.sv ====
// I2C bus master model for the EEPROM DIP switch block
`default_nettype none
module eedip_master (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_m
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'h1;
    sda_m = 1'h1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic start();
    tick(1);
    sda_m <= 1'h1;
    tick(2);
    scl <= 1'h1;
    tick(3);
    sda_m <= 1'h0;
    tick(3);
    scl <= 1'h0;
  endtask
  task automatic stop();
    tick(1);
    sda_m <= 1'h0;
    tick(2);
    scl <= 1'h1;
    tick(3);
    sda_m <= 1'h1;
    tick(3);
  endtask
  // Eight bits MSB first, ninth left released
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic [8:0] sh;
    sh = {tx, 1'h1};
    for (int i = 8; i >= 0; i--) begin
      tick(1);
      sda_m <= sh[i];
      tick(2);
      scl <= 1'h1;
      tick(2);
      sh[i] = sda_line;
      tick(2);
      scl <= 1'h0;
    end
    rx = sh[8:1];
    ack = !sh[0];
  endtask
endmodule
`default_nettype wire

// ==== test/i2c_eeprom_dip_switch_io_bench.sv ====
// Bench for the EEPROM DIP switch block
`default_nettype none
`include "eedip_cfg.svh"
module i2c_eeprom_dip_switch_io_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, resetn = 1'h0, address_strap = 1'h1, write_protect = 1'h0;
  logic source_select = 1'h1, output_force_lown = 1'h1, gpio_force_lown = 1'h1, ack;
  logic [4:0] mux_in = 5'h15;
  logic [7:0] gpio_in = 8'hA5, rx;
  wire logic scl, sda_m, sda_out, sda_oe;
  wire logic [7:0] gpio_out, gpio_oe;
  wire eedip_pkg::eedip_sw_out_t sw_drive_low;
  wire logic sda_line = sda_m & ~sda_oe;
  int fail_count = 0, checked = 0;
  eedip_master m_u (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
  eedip_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_strap(address_strap),
    .write_protect(write_protect), .source_select(source_select),
    .output_force_lown(output_force_lown), .gpio_force_lown(gpio_force_lown),
    .mux_in(mux_in), .sw_drive_low(sw_drive_low), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  initial forever #20 sys_clk = ~sys_clk;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic addr(input logic rw);
    m_u.start();
    m_u.xfer({`EEDIP_ADDR_FIXED, address_strap, rw}, rx, ack);
    check("addr ack", {7'h00, ack}, 8'h01);
  endtask
  task automatic write2(input logic [7:0] cmd, input logic [7:0] d, input logic ok);
    addr(1'h0);
    m_u.xfer(cmd, rx, ack);
    check("cmd ack", {7'h00, ack}, 8'h01);
    m_u.xfer(d, rx, ack);
    check("data ack", {7'h00, ack}, {7'h00, ok});
    m_u.stop();
  endtask
  task automatic read1(input logic [7:0] cmd, input logic [7:0] mask, input logic [7:0] exp);
    addr(1'h0);
    m_u.xfer(cmd, rx, ack);
    addr(1'h1);
    m_u.xfer(8'hFF, rx, ack);
    m_u.stop();
    check("read data", rx & mask, exp);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'h1;
    settle();
    check("gpio oe", gpio_oe, 8'hFF);
    m_u.start();
    m_u.xfer({`EEDIP_ADDR_FIXED, 1'h0, 1'h0}, rx, ack);
    m_u.stop();
    check("other addr", {7'h00, ack}, 8'h00);
    write2(`EEDIP_CMD_SW_WR, 8'h2B, 1'h1);
    write_protect <= 1'h1;
    write2(`EEDIP_CMD_SW_WR, 8'h11, 1'h0);
    read1(`EEDIP_CMD_SW_RD, 8'h3F, 8'h2B);
    read1(`EEDIP_CMD_IN_RD, 8'hFF, 8'hA5);
    read1(`EEDIP_CMD_MUXIN, 8'hFF, 8'h15);
    $display("test bus done");
    write_protect <= 1'h0;
    write2(`EEDIP_CMD_MEM_WR, 8'h5C, 1'h1);
    write2(`EEDIP_CMD_IN_TO_MEM, 8'h00, 1'h1);
    read1(`EEDIP_CMD_MEM_RD, 8'hFF, 8'hA5);
    write2(`EEDIP_CMD_MEM_TO_OUT, 8'h00, 1'h1);
    settle();
    check("mem to out", gpio_oe, 8'h5A);
    resetn <= 1'h0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'h1;
    settle();
    check("gpio reset", gpio_oe, 8'hFF);
    write2(`EEDIP_CMD_CFG, 8'h0F, 1'h1);
    settle();
    check("gpio cfg", gpio_oe, 8'h0F);
    $display("test memory done");
    source_select <= 1'h0;
    settle();
    check("stored drive", {2'h0, sw_drive_low}, 8'h28);
    source_select <= 1'h1;
    settle();
    check("hw drive", {2'h0, sw_drive_low}, 8'h14);
    output_force_lown <= 1'h0;
    gpio_force_lown <= 1'h0;
    settle();
    check("forced mux", {3'h0, sw_drive_low.mux_out}, 8'h1F);
    check("forced gpio", gpio_oe, 8'hFF);
    $display("test pins done");
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
